//--- bench/eeprom_access_ctrl_properties.sv
// Purpose: Port properties of the EEPROM access block
// Assumes: One clock, sync reset
// Notes:   Bound from the bench top
`timescale 1ns/10ps
module eeprom_access_ctrl_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register ports
  input wire logic        fb_we,
  input wire logic [15:0] fb_addr,
  input wire logic [7:0]  fb_rdata,
  input wire logic        host_we,
  input wire logic [15:0] host_addr,
  input wire logic [7:0]  host_rdata,
  // Pins and engine
  input wire logic        emul_pin,
  input wire logic        rd8_pin,
  input wire logic        op_start,
  input wire logic [2:0]  op_cmd,
  input wire logic        op_done,
  input wire logic        load_done,
  input wire logic        load_ok,
  input wire logic        csum_err,
  input wire logic        app_layer_event_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Properties
  start_pulse_a: assert property (op_start |=> !op_start)
    else $error("start longer than a cycle");
  start_cmd_a: assert property (op_start |-> op_cmd inside {3'h1, 3'h2, 3'h4})
    else $error("start with bad command");
  done_clear_a: assert property (op_done && op_cmd != 3'h0 |=> op_cmd == 3'h0)
    else $error("command kept after done");
  cmd_view_a: assert property (fb_addr == 16'h0503 |-> fb_rdata[2:0] == op_cmd
    && fb_rdata[7] == (op_cmd != 3'h0)) else $error("command or busy view wrong");
  host_wen_a: assert property (host_addr == 16'h0501 && host_rdata[0]
    && fb_addr == 16'h0502 |-> fb_rdata[0]) else $error("enable low while host owns");
  force_drop_a: assert property (fb_addr == 16'h0500 && fb_rdata[1]
    ##1 host_addr == 16'h0501 |-> !host_rdata[0]) else $error("host kept ownership");
  strap_view_a: assert property ($stable({emul_pin, rd8_pin})[*4]
    ##0 fb_addr == 16'h0502 |-> fb_rdata[6:5] == {rd8_pin, emul_pin})
    else $error("mode bits wrong");
  csum_view_a: assert property (!$past(rst) && $stable(csum_err)
    && fb_addr == 16'h0503 |-> fb_rdata[3] == csum_err) else $error("checksum bit wrong");
  load_view_a: assert property (load_done && load_ok
    ##1 fb_addr == 16'h0503 |-> !fb_rdata[4]) else $error("load bit still set");
  event_rise_a: assert property ($rose(app_layer_event_request)
    |-> $past(host_we) || $past(fb_we)) else $error("event without command");
  event_ack_a: assert property (!$past(rst) && $fell(app_layer_event_request)
    |-> $past(host_we) && $past(host_addr) == 16'h0503) else $error("event dropped");
  cover property (op_start && op_cmd == 3'h2);
  cover property ($fell(app_layer_event_request));
  cover property (op_done && op_cmd == 3'h1);
endmodule : eeprom_access_ctrl_chk

//--- bench/eeprom_engine_model.sv
// Purpose: Transfer engine and EEPROM stand-in
// Assumes: Latency and refusal set by the bench
// Notes:   Read data is inverted except in the cycle of a done or nack pulse
`timescale 1ns/10ps
module eeprom_engine_model
  import eeprom_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Engine side
  input  wire logic        op_start,
  input  wire logic [2:0]  op_cmd,
  output logic             op_done,
  output logic             op_nack,
  output logic             op_rd_valid,
  output logic [63:0]      op_rd_data,
  output logic             load_done,
  output logic             load_ok,
  // Bench controls
  input  wire logic [7:0]  lat,
  input  wire logic        nack_req
);
  localparam logic [63:0] PAT = 64'h8877665544332211;
  logic [7:0] cnt;
  logic [3:0] boot;
  assign load_ok = 1'b1;
  always_ff @(posedge clk)
  begin
    op_done     <= 1'b0;
    op_nack     <= 1'b0;
    op_rd_valid <= 1'b0;
    load_done   <= (boot == 4'h1);
    op_rd_data  <= ~PAT;
    cnt         <= op_start ? lat : cnt - (cnt != 8'h00);
    boot        <= boot - (boot != 4'h0);
    if (rst)
    begin
      cnt  <= 8'h00;
      boot <= 4'h6;
    end
    else if (cnt == 8'h01)
    begin
      op_nack     <= nack_req;
      op_done     <= !nack_req;
      op_rd_valid <= !nack_req && op_cmd == CMD_READ;
      op_rd_data  <= PAT;
    end
  end
endmodule : eeprom_engine_model

//--- bench/tb_eeprom_access_ctrl.sv
// Purpose: Self-checking bench for the EEPROM access block
// Assumes: Inputs change at the falling edge
// Notes:   hw code: bit1 host side, bit0 write
`timescale 1ns/10ps
module tb_eeprom_access_ctrl
  import eeprom_ctrl_pkg::*;
;
  typedef struct packed {
    logic [1:0]  hw;
    logic [15:0] a;
    logic [7:0]  d;
    logic [7:0]  m;
    logic [7:0]  e;
  } row_t;
  logic        clk, rst, fb_we, host_we, frame_start, emul_pin, rd8_pin, algo_pin;
  logic        op_start, op_done, op_nack, op_rd_valid, load_done, load_ok, csum_err;
  logic        app_layer_event_request, nack_req;
  logic [15:0] fb_addr, host_addr, op_wdata;
  logic [7:0]  fb_wdata, fb_rdata, host_wdata, host_rdata, lat;
  logic [2:0]  op_cmd;
  logic [31:0] op_addr;
  logic [63:0] op_rd_data;
  int          failures = 0;
  int          check_count = 0;
  logic [7:0]  seen;
  logic [2:0]  cmds[3] = '{CMD_READ, CMD_WRITE, CMD_RELOAD};
  row_t        rows[12] = '{
    '{2'h0, 16'h0500, 8'h00, 8'hff, 8'h00}, '{2'h3, 16'h0501, 8'h01, 8'h01, 8'h00},
    '{2'h3, 16'h0500, 8'h03, 8'h03, 8'h00}, '{2'h1, 16'h0500, 8'h01, 8'h03, 8'h01},
    '{2'h3, 16'h0501, 8'h01, 8'h01, 8'h01}, '{2'h0, 16'h0502, 8'h00, 8'h01, 8'h01},
    '{2'h1, 16'h0503, 8'h01, 8'he7, 8'h00}, '{2'h1, 16'h0500, 8'h03, 8'h03, 8'h03},
    '{2'h2, 16'h0501, 8'h00, 8'h01, 8'h00}, '{2'h3, 16'h0501, 8'h01, 8'h01, 8'h00},
    '{2'h1, 16'h0500, 8'h00, 8'h03, 8'h00}, '{2'h1, 16'h0502, 8'h01, 8'h01, 8'h01}};

  eeprom_access_ctrl DUT (
    .clk                     (clk),
    .rst                     (rst),
    .fb_we                   (fb_we),
    .fb_addr                 (fb_addr),
    .fb_wdata                (fb_wdata),
    .fb_rdata                (fb_rdata),
    .frame_start             (frame_start),
    .host_we                 (host_we),
    .host_addr               (host_addr),
    .host_wdata              (host_wdata),
    .host_rdata              (host_rdata),
    .emul_pin                (emul_pin),
    .rd8_pin                 (rd8_pin),
    .algo_pin                (algo_pin),
    .op_start                (op_start),
    .op_cmd                  (op_cmd),
    .op_addr                 (op_addr),
    .op_wdata                (op_wdata),
    .op_done                 (op_done),
    .op_nack                 (op_nack),
    .op_rd_valid             (op_rd_valid),
    .op_rd_data              (op_rd_data),
    .load_done               (load_done),
    .load_ok                 (load_ok),
    .csum_err                (csum_err),
    .app_layer_event_request (app_layer_event_request)
  );
  eeprom_engine_model partner (
    .clk         (clk),
    .rst         (rst),
    .op_start    (op_start),
    .op_cmd      (op_cmd),
    .op_done     (op_done),
    .op_nack     (op_nack),
    .op_rd_valid (op_rd_valid),
    .op_rd_data  (op_rd_data),
    .load_done   (load_done),
    .load_ok     (load_ok),
    .lat         (lat),
    .nack_req    (nack_req)
  );

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic acc(input logic [1:0] hw, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    host_we    = hw[1] & hw[0];
    fb_we      = !hw[1] & hw[0];
    host_wdata = d;
    fb_wdata   = d;
    if (hw[1])
      host_addr = a;
    else
      fb_addr = a;
    @(negedge clk);
    host_we = 1'b0;
    fb_we   = 1'b0;
    #1;
  endtask : acc

  task automatic wait_low(input logic [7:0] m);
    int n;
    n = 0;
    while ((fb_rdata & m) !== 8'h00 && n < 60)
    begin
      @(negedge clk);
      #1;
      n++;
    end
    if ((fb_rdata & m) !== 8'h00)
    begin
      failures++;
      $display("MISMATCH wait expected 00 seen %h", fb_rdata & m);
      wrap_up();
    end
  endtask : wait_low

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    {fb_we, host_we, frame_start, emul_pin, rd8_pin, algo_pin, csum_err, nack_req} = 8'h00;
    {fb_addr, host_addr, fb_wdata, host_wdata} = 48'h0;
    lat = 8'h08;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    acc(2'h0, 16'h0503, 8'h00);
    chk("load busy", 8'h10, fb_rdata & 8'h10);
    wait_low(8'h10);
    foreach (rows[i])
    begin
      acc(rows[i].hw, rows[i].a, rows[i].d);
      seen = rows[i].hw[1] ? host_rdata : fb_rdata;
      chk("row", rows[i].e, seen & rows[i].m);
    end
    $display("test rows done");
    frame_start = 1'b1;
    @(negedge clk);
    frame_start = 1'b0;
    acc(2'h0, 16'h0502, 8'h00);
    chk("wr enable", 8'h00, fb_rdata & 8'h01);
    acc(2'h1, 16'h0503, {5'h00, CMD_WRITE});
    chk("no enable", 8'h40, fb_rdata & 8'hc7);
    acc(2'h1, 16'h0503, 8'h03);
    chk("bad cmd", 8'h20, fb_rdata & 8'ha7);
    acc(2'h1, 16'h0503, 8'h01);
    chk("cmd held", 8'h20, fb_rdata & 8'ha7);
    acc(2'h1, 16'h0503, 8'h00);
    chk("err clear", 8'h00, fb_rdata & 8'he7);
    csum_err = 1'b1;
    acc(2'h0, 16'h0503, 8'h00);
    chk("csum", 8'h08, fb_rdata & 8'h08);
    csum_err = 1'b0;
    nack_req = 1'b1;
    lat = 8'h02;
    acc(2'h1, 16'h0503, 8'h01);
    wait_low(8'h80);
    chk("nack", 8'h20, fb_rdata & 8'ha7);
    $display("test errors done");
    nack_req = 1'b0;
    lat = 8'h08;
    acc(2'h1, 16'h0503, 8'h00);
    chk("nack clear", 8'h00, fb_rdata & 8'ha7);
    acc(2'h1, 16'h0502, 8'h01);
    acc(2'h1, 16'h0504, 8'h5a);
    chk("op addr", 8'h5a, op_addr[7:0]);
    acc(2'h1, 16'h0509, 8'hc3);
    chk("op wdata", 8'hc3, op_wdata[15:8]);
    foreach (cmds[i])
    begin
      acc(2'h1, 16'h0503, {5'h00, cmds[i]});
      chk("start", {5'h10, cmds[i]}, fb_rdata);
      acc(2'h1, 16'h0502, 8'h00);
      chk("busy lock", 8'h01, fb_rdata & 8'h01);
      acc(2'h0, 16'h0503, 8'h00);
      wait_low(8'h80);
      chk("cmd end", 8'h00, fb_rdata & 8'h07);
    end
    acc(2'h0, 16'h050f, 8'h00);
    chk("read data", 8'h88, fb_rdata);
    $display("test commands done");
    {emul_pin, rd8_pin} = 2'h3;
    acc(2'h1, 16'h0500, 8'h01);
    acc(2'h3, 16'h0501, 8'h01);
    acc(2'h3, 16'h0502, 8'h80);
    chk("algo", 8'h80, host_rdata & 8'h80);
    acc(2'h0, 16'h0502, 8'h00);
    chk("straps", 8'h61, fb_rdata & 8'h61);
    acc(2'h3, 16'h0503, 8'h01);
    chk("emul busy", 8'h81, host_rdata & 8'h87);
    chk("event", 8'h01, {7'h00, app_layer_event_request});
    acc(2'h3, 16'h0503, 8'h01);
    chk("emul ack", 8'h00, host_rdata & 8'h87);
    chk("event off", 8'h00, {7'h00, app_layer_event_request});
    acc(2'h3, 16'h0503, 8'h04);
    acc(2'h3, 16'h0503, 8'h24);
    chk("emul fail", 8'h20, host_rdata & 8'ha0);
    $display("test emulation done");
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    acc(2'h2, 16'h0501, 8'h00);
    chk("reset own", 8'h00, host_rdata);
    acc(2'h0, 16'h0503, 8'h00);
    chk("reset ctrl", 8'h10, fb_rdata);
    $display("test reset done");
    wrap_up();
  end
endmodule : tb_eeprom_access_ctrl

bind eeprom_access_ctrl eeprom_access_ctrl_chk checker_i (
  .clk                     (clk),
  .rst                     (rst),
  .fb_we                   (fb_we),
  .fb_addr                 (fb_addr),
  .fb_rdata                (fb_rdata),
  .host_we                 (host_we),
  .host_addr               (host_addr),
  .host_rdata              (host_rdata),
  .emul_pin                (emul_pin),
  .rd8_pin                 (rd8_pin),
  .op_start                (op_start),
  .op_cmd                  (op_cmd),
  .op_done                 (op_done),
  .load_done               (load_done),
  .load_ok                 (load_ok),
  .csum_err                (csum_err),
  .app_layer_event_request (app_layer_event_request)
);

//--- common/eeprom_ctrl_pkg.sv
// Purpose: Constants and types for the configuration EEPROM access control block
// Assumes: Byte-wide register ports from the fieldbus side and the local host port
// Notes:   Offsets are byte addresses in the controller register space
package eeprom_ctrl_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [15:0] OFS_OWN_CFG     = 16'h0500;
  localparam logic [15:0] OFS_HOST_ACCESS = 16'h0501;
  localparam logic [15:0] OFS_CTRL_LO     = 16'h0502;
  localparam logic [15:0] OFS_CTRL_HI     = 16'h0503;
  localparam logic [15:0] OFS_ADDR_BASE   = 16'h0504;
  localparam logic [15:0] OFS_DATA_BASE   = 16'h0508;
  localparam int          ADDR_BYTES      = 4;
  localparam int          DATA_BYTES      = 8;

  // ==========================================================================
  // Field positions
  localparam int BIT_OFFER     = 0;
  localparam int BIT_FORCE     = 1;
  localparam int BIT_HOST_OWN  = 0;
  localparam int BIT_WR_EN     = 0;
  localparam int BIT_EMUL      = 5;
  localparam int BIT_RD8       = 6;
  localparam int BIT_ALGO      = 7;
  localparam int CMD_LSB       = 8;
  localparam int BIT_CSUM_ERR  = 11;
  localparam int BIT_LOAD_NA   = 12;
  localparam int BIT_ACK_ERR   = 13;
  localparam int BIT_WEN_ERR   = 14;
  localparam int BIT_BUSY      = 15;
  localparam int EVT_EEPROM    = 5;

  // ==========================================================================
  // Commands
  localparam logic [2:0] CMD_IDLE   = 3'h0;
  localparam logic [2:0] CMD_READ   = 3'h1;
  localparam logic [2:0] CMD_WRITE  = 3'h2;
  localparam logic [2:0] CMD_RELOAD = 3'h4;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] OWN_CFG_RESET = 8'h00;
  localparam logic       LOAD_NA_RESET = 1'b1;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_EMUL_WAIT} op_state_t;

  // Valid command decode
  function automatic logic cmd_valid(input logic [2:0] c);
    return (c == CMD_READ) || (c == CMD_WRITE) || (c == CMD_RELOAD);
  endfunction : cmd_valid

endpackage : eeprom_ctrl_pkg

//--- src/eeprom_access_ctrl.sv
// Purpose: Register control of the configuration EEPROM interface
// Assumes: Byte register ports for fieldbus side and local host port, one clock
// Notes:   Transfer engine outside; strap pins sampled through synchronisers
//
// How it works
// - Config bit 0, fieldbus-written, offers EEPROM control to the local host
// - Force bit 1 or a cleared offer bit 0 clears host ownership
// - Host takes/releases ownership only while offered and not forced
// - Control bit 0 gates fieldbus writes; reads 1 while host owns
// - Write enable clears at start of next received frame
// - Control bit 5 reports emulation mode
// - Control bit 6 reports 4 or 8 byte reads
// - Control bit 7 selects address bytes; host may write in emulation
// - Command field 000 idle, 001 read, 010 write, 100 reload; reads running command
// - Command field clears when busy ends
// - Non-idle command writes ignored while acknowledge error set
// - Control bit 11 flags checksum error
// - Control bit 12 is 1 until load completes successfully
// - Bit 13 set on missing acknowledge, invalid command, or host emulation fault
// - Bit 14 set on write command without write enable
// - Control bit 15 is busy
// - Idle or valid command write clears both error bits
// - Only owner writes qualified fields; all blocked while busy
// - Emulating host acknowledges by writing command back, clearing event bit 5
`timescale 1ns/10ps
module eeprom_access_ctrl
  import eeprom_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Fieldbus side register port
  input  wire logic        fb_we,
  input  wire logic [15:0] fb_addr,
  input  wire logic [7:0]  fb_wdata,
  output logic [7:0]       fb_rdata,
  input  wire logic        frame_start,
  // Local host port register port
  input  wire logic        host_we,
  input  wire logic [15:0] host_addr,
  input  wire logic [7:0]  host_wdata,
  output logic [7:0]       host_rdata,
  // Straps (pins)
  input  wire logic        emul_pin,
  input  wire logic        rd8_pin,
  input  wire logic        algo_pin,
  // Transfer engine
  output logic             op_start,
  output logic [2:0]       op_cmd,
  output logic [31:0]      op_addr,
  output logic [15:0]      op_wdata,
  input  wire logic        op_done,
  input  wire logic        op_nack,
  input  wire logic        op_rd_valid,
  input  wire logic [63:0] op_rd_data,
  input  wire logic        load_done,
  input  wire logic        load_ok,
  input  wire logic        csum_err,
  // Event to application layer
  output logic             app_layer_event_request
);

  // ==========================================================================
  // Synchronised straps
  logic [2:0] straps;

  sync2 #(.W(3)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({algo_pin, rd8_pin, emul_pin}),
    .q   (straps)
  );

  // ==========================================================================
  // State
  typedef struct packed {
    op_state_t   st;
    logic        wr_en;
    logic        algo;
    logic        algo_init;
    logic [2:0]  cmd;
    logic        csum_err;
    logic        load_na;
    logic        ack_err;
    logic        wen_err;
    logic        busy;
    logic [31:0] addr;
    logic [63:0] data;
    logic        evt;
    logic        start;
  } ctl_state_t;

  ctl_state_t st_reg;
  ctl_state_t st_next;

  logic [7:0] own_cfg;
  logic       host_owns;
  logic       emul;

  assign emul = straps[0];

  // Host claims are ignored while a transfer runs; force or offer clear still drops ownership
  ownership_arbiter u_arb (
    .clk            (clk),
    .rst            (rst),
    .fb_cfg_we      (fb_we && fb_addr == OFS_OWN_CFG),
    .fb_cfg_wdata   (fb_wdata),
    .host_acc_we    (host_we && host_addr == OFS_HOST_ACCESS),
    .host_acc_wdata (host_wdata[BIT_HOST_OWN]),
    .busy           (st_reg.busy),
    .own_cfg        (own_cfg),
    .host_owns      (host_owns)
  );

  // ==========================================================================
  // Control word as read
  logic [15:0] ctrl_word;

  always_comb
  begin
    ctrl_word                 = '0;
    ctrl_word[BIT_WR_EN]      = st_reg.wr_en | host_owns;
    ctrl_word[BIT_EMUL]       = emul;
    ctrl_word[BIT_RD8]        = straps[1];
    ctrl_word[BIT_ALGO]       = st_reg.algo;
    ctrl_word[CMD_LSB+:3]     = st_reg.cmd;
    ctrl_word[BIT_CSUM_ERR]   = st_reg.csum_err;
    ctrl_word[BIT_LOAD_NA]    = st_reg.load_na;
    ctrl_word[BIT_ACK_ERR]    = st_reg.ack_err;
    ctrl_word[BIT_WEN_ERR]    = st_reg.wen_err;
    ctrl_word[BIT_BUSY]       = st_reg.busy;
  end

  // ==========================================================================
  // Window decode
  function automatic logic in_addr_win(input logic [15:0] a);
    return (a >= OFS_ADDR_BASE) && (a < OFS_ADDR_BASE + 16'(ADDR_BYTES));
  endfunction : in_addr_win

  function automatic logic in_data_win(input logic [15:0] a);
    return (a >= OFS_DATA_BASE) && (a < OFS_DATA_BASE + 16'(DATA_BYTES));
  endfunction : in_data_win

  // Both ports share one read decoder
  function automatic logic [7:0] rd_mux(input logic [15:0] a, input ctl_state_t s,
                                        input logic [7:0] cfg, input logic own,
                                        input logic [15:0] cw);
    logic [7:0] r;
    r = 8'h00;
    if (a == OFS_OWN_CFG)
      r = cfg;
    else if (a == OFS_HOST_ACCESS)
      r = {7'h00, own};
    else if (a == OFS_CTRL_LO)
      r = cw[7:0];
    else if (a == OFS_CTRL_HI)
      r = cw[15:8];
    else if (in_addr_win(a))
      r = s.addr[8*(a[1:0])+:8];
    else if (in_data_win(a))
      r = s.data[8*(a[2:0])+:8];
    return r;
  endfunction : rd_mux

  // ==========================================================================
  // Write qualification
  logic       own_we;
  logic [15:0] own_addr;
  logic [7:0]  own_wdata;
  logic        fb_owner_we;
  logic        host_owner_we;

  always_comb
  begin
    fb_owner_we   = fb_we && !host_owns;
    host_owner_we = host_we && host_owns;
    own_we        = fb_owner_we || host_owner_we;
    own_addr      = host_owner_we ? host_addr : fb_addr;
    own_wdata     = host_owner_we ? host_wdata : fb_wdata;
  end

  // ==========================================================================
  // Next state
  logic [2:0] new_cmd;
  logic       cmd_wr;
  logic       emul_wr;
  logic       host_ack;

  always_comb
  begin
    st_next          = st_reg;
    st_next.start    = 1'b0;
    st_next.csum_err = csum_err;
    new_cmd          = own_wdata[2:0];
    cmd_wr           = own_we && own_addr == OFS_CTRL_HI && !st_reg.busy;
    emul_wr          = host_we && emul && st_reg.busy;
    host_ack         = emul_wr && host_addr == OFS_CTRL_HI && host_wdata[2:0] == st_reg.cmd;

    // Algorithm bit loaded once after reset from the synchronised strap, which then still holds its reset 0
    if (!st_reg.algo_init)
    begin
      st_next.algo      = straps[2];
      st_next.algo_init = 1'b1;
    end
    if (load_done)
      st_next.load_na = !load_ok;

    // Fieldbus write wins over a frame start clear
    if (frame_start)
      st_next.wr_en = 1'b0;
    if (fb_owner_we && fb_addr == OFS_CTRL_LO && !st_reg.busy)
      st_next.wr_en = fb_wdata[BIT_WR_EN];

    if (host_we && emul && host_addr == OFS_CTRL_LO)
      st_next.algo = host_wdata[BIT_ALGO];

    if (own_we && !st_reg.busy)
    begin
      if (in_addr_win(own_addr))
        st_next.addr[8*(own_addr[1:0])+:8] = own_wdata;
      // Only the two low data bytes take writes
      if (own_addr == OFS_DATA_BASE || own_addr == OFS_DATA_BASE + 16'h0001)
        st_next.data[8*(own_addr[0])+:8] = own_wdata;
    end

    // Command start; idle still clears errors while bit 13 is pending
    if (cmd_wr && (!st_reg.ack_err || new_cmd == CMD_IDLE))
    begin
      if (new_cmd == CMD_IDLE || cmd_valid(new_cmd))
      begin
        st_next.ack_err = 1'b0;
        st_next.wen_err = 1'b0;
      end
      if (!cmd_valid(new_cmd) && new_cmd != CMD_IDLE)
        st_next.ack_err = 1'b1;
      else if (new_cmd == CMD_WRITE && !(st_reg.wr_en || host_owns))
        st_next.wen_err = 1'b1;
      else if (cmd_valid(new_cmd))
      begin
        st_next.cmd   = new_cmd;
        st_next.busy  = 1'b1;
        st_next.start = !emul;
        st_next.evt   = emul;
        st_next.st    = emul ? ST_EMUL_WAIT : ST_RUN;
      end
    end

    unique case (st_reg.st)
      ST_IDLE: ;
      ST_RUN:
      begin
        if (op_rd_valid)
          st_next.data = op_rd_data;
        if (op_done || op_nack)
        begin
          st_next.ack_err = op_nack;
          st_next.busy    = 1'b0;
          st_next.cmd     = CMD_IDLE;
          st_next.st      = ST_IDLE;
        end
      end
      ST_EMUL_WAIT:
      begin
        // Emulating host fills read data while busy
        if (emul_wr && in_data_win(host_addr) && st_reg.cmd != CMD_WRITE)
          st_next.data[8*(host_addr[2:0])+:8] = host_wdata;
        if (host_ack)
        begin
          st_next.ack_err = host_wdata[BIT_ACK_ERR-8];
          st_next.evt     = 1'b0;
          st_next.busy    = 1'b0;
          st_next.cmd     = CMD_IDLE;
          st_next.st      = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg         <= '0;
      st_reg.st      <= ST_IDLE;
      st_reg.load_na <= LOAD_NA_RESET;
    end
    else
      st_reg <= st_next;
  end

  // ==========================================================================
  // Outputs
  assign fb_rdata                = rd_mux(fb_addr, st_reg, own_cfg, host_owns, ctrl_word);
  assign host_rdata              = rd_mux(host_addr, st_reg, own_cfg, host_owns, ctrl_word);
  assign op_start                = st_reg.start;
  assign op_cmd                  = st_reg.cmd;
  assign op_addr                 = st_reg.addr;
  // Engine sees the low data word as write data
  assign op_wdata                = st_reg.data[15:0];
  assign app_layer_event_request = st_reg.evt;

endmodule : eeprom_access_ctrl

//--- src/ownership_arbiter.sv
// Purpose: Decides which side owns the EEPROM interface
// Assumes: Write strobes are one-cycle pulses on clk
// Notes:   Force bit overrides any host claim
`timescale 1ns/10ps
module ownership_arbiter
  import eeprom_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Fieldbus side configuration write
  input  wire logic       fb_cfg_we,
  input  wire logic [7:0] fb_cfg_wdata,
  // Local host access write
  input  wire logic       host_acc_we,
  input  wire logic       host_acc_wdata,
  input  wire logic       busy,
  // State
  output logic [7:0]      own_cfg,
  output logic            host_owns
);

  typedef struct packed {
    logic [7:0] cfg;
    logic       own;
  } arb_state_t;

  arb_state_t st_reg;
  arb_state_t st_next;

  always_comb
  begin
    st_next = st_reg;
    if (fb_cfg_we)
      st_next.cfg = fb_cfg_wdata;
    if (host_acc_we && !busy && st_reg.cfg[BIT_OFFER] && !st_reg.cfg[BIT_FORCE])
      st_next.own = host_acc_wdata;
    if (st_next.cfg[BIT_FORCE])
      st_next.own = 1'b0;
    if (!st_next.cfg[BIT_OFFER])
      st_next.own = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_reg <= {OWN_CFG_RESET, 1'b0};
    else
      st_reg <= st_next;
  end

  assign own_cfg   = st_reg.cfg;
  assign host_owns = st_reg.own;

endmodule : ownership_arbiter

//--- src/sync2.sv
// Purpose: Two flip-flop synchroniser for pin levels
// Assumes: Input is asynchronous to clk
// Notes:   First stage is read only by the second
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Level in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  always_comb
  begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign q = st_reg.s2;

endmodule : sync2
